// ==== pcm_pkg.sv ====
/*
 * Package for the press contact monitor: register map, field positions,
 * reset values, timing constants and the shared state structs.
 * Assumes a 40 MHz logic clock and an AXI4-Lite register master.
 */
// Contract
// - Restart input enabled: valid pulse clears faults
// - Valid pulse: high min 100/350 ms, max 30 s
// - Restart disabled: faults held until reset
// - Setting enables overrun zone contact evaluation
// - Overrun contact pulses once per cycle
// - Overrun or top contact always high
// - Bottom rise with top high sets upstroke
// - Count 1: bottom rises exactly once per cycle
// - Count 0-2: zero to two bottom rises accepted
// - Second bottom rise does not re-raise upstroke
// - Count 1: bottom low when top rises
// - Error flag setting enables any_fault output
// - any_fault means sequence or overrun fault
// - Fault drops release, raises fault and rearm
// - Release input low suspends monitoring, release low
// - Start must rise in top zone, else overrun; code also accepts start high at overrun fall
// - Upstroke drops at top or bottom fall
package pcm_pkg;
    localparam int unsigned CLK_HZ = 40_000_000;
    localparam int unsigned TICK_MS = 1;
    localparam int unsigned TICK_CYC = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned MIN_SHORT_MS = 100;
    localparam int unsigned MIN_LONG_MS = 350;
    localparam int unsigned MAX_PULSE_MS = 30_000;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_STAT = 32'h0000_0004;
    localparam int CTRL_RESTART_EN = 0;
    localparam int CTRL_OVR_EN = 1;
    localparam int CTRL_COUNT_02 = 2;
    localparam int CTRL_MIN_LONG = 3;
    localparam int CTRL_FLAG_EN = 4;
    localparam logic [4:0] CTRL_RESET = 5'h01;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic release_out;
        logic top_zone;
        logic upstroke_zone;
        logic rearm_needed;
        logic sequence_fault;
        logic overrun_fault;
        logic any_fault;
    } pcm_out_s;

    typedef struct packed {
        logic [2:0] top_sync;
        logic [2:0] bot_sync;
        logic [2:0] ovr_sync;
        logic [2:0] rst_sync;
        logic top_prev;
        logic bot_prev;
        logic ovr_prev;
        logic rst_prev;
        logic start_prev;
        logic rel_prev;
        logic [1:0] bot_count;
        logic bot_armed;
        logic ovr_seen;
        logic start_ok;
        logic up_used;
        logic [15:0] tick_cnt;
        logic [15:0] ms_cnt;
        logic pulse_live;
        pcm_out_s out;
        logic [4:0] ctrl;
        logic awv;
        logic [31:0] awaddr;
        logic wv;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pcm_state_s;
endpackage : pcm_pkg

// ==== pcm_monitor.sv ====
/*
 * Press contact monitor: checks the order of the top, bottom and overrun
 * zone contacts, drives zone and fault outputs, and holds faults until a
 * timed restart pulse. Configuration and status sit behind AXI4-Lite.
 * Assumes contact and restart pins are asynchronous; start and release come
 * from logic on aclk.
 */
`timescale 1ns/1ps
module pcm_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic top_position_contact,
    input wire logic bottom_position_contact,
    input wire logic overrun_zone_contact,
    input wire logic restart_in,
    input wire logic start_in,
    input wire logic release_in,
    output logic release_out,
    output logic top_zone,
    output logic upstroke_zone,
    output logic rearm_needed,
    output logic sequence_fault,
    output logic overrun_fault,
    output logic any_fault,
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    pcm_pkg::pcm_state_s q, d;
    logic top, bot, ovr, rst;
    logic top_rise, top_fall, bot_rise, bot_fall, ovr_rise, ovr_fall, rst_fall, start_rise;
    logic monitor_on, seq_err, ovr_err, pulse_ok, wr_go;
    logic [15:0] min_ms;

    // Filtered levels: a change counts when stages two and three agree
    assign top = (q.top_sync[1] == q.top_sync[2]) ? q.top_sync[2] : q.top_prev;
    assign bot = (q.bot_sync[1] == q.bot_sync[2]) ? q.bot_sync[2] : q.bot_prev;
    assign ovr = (q.ovr_sync[1] == q.ovr_sync[2]) ? q.ovr_sync[2] : q.ovr_prev;
    assign rst = (q.rst_sync[1] == q.rst_sync[2]) ? q.rst_sync[2] : q.rst_prev;

    assign top_rise = top & ~q.top_prev;
    assign top_fall = ~top & q.top_prev;
    assign bot_rise = bot & ~q.bot_prev;
    assign bot_fall = ~bot & q.bot_prev;
    assign ovr_rise = ovr & ~q.ovr_prev;
    assign ovr_fall = ~ovr & q.ovr_prev;
    assign rst_fall = ~rst & q.rst_prev;
    assign start_rise = start_in & ~q.start_prev;

    assign min_ms = q.ctrl[pcm_pkg::CTRL_MIN_LONG] ? 16'(pcm_pkg::MIN_LONG_MS)
                                                     : 16'(pcm_pkg::MIN_SHORT_MS);
    assign pulse_ok = rst_fall & q.pulse_live & (q.ms_cnt >= min_ms)
                    & (q.ms_cnt <= 16'(pcm_pkg::MAX_PULSE_MS));

    // Monitoring runs only with release input high and no fault
    assign monitor_on = release_in & ~q.out.sequence_fault & ~q.out.overrun_fault;

    always_comb begin
        seq_err = 1'b0;
        ovr_err = 1'b0;
        if (monitor_on && q.rel_prev) begin
            // Overrun and top contact may never both be low
            if (q.ctrl[pcm_pkg::CTRL_OVR_EN] && !ovr && !top) begin
                seq_err = 1'b1;
            end
            // One overrun pulse per cycle: a missing one checked at top fall, a second one at overrun rise
            if (q.ctrl[pcm_pkg::CTRL_OVR_EN] && top_fall && !q.ovr_seen) begin
                seq_err = 1'b1;
            end
            if (q.ctrl[pcm_pkg::CTRL_OVR_EN] && ovr_rise && q.ovr_seen) begin
                seq_err = 1'b1;
            end
            // Count 1: exactly one bottom rise per cycle
            if (!q.ctrl[pcm_pkg::CTRL_COUNT_02]) begin
                if ((top_fall && q.bot_count != 2'd1) || (bot_rise && q.bot_count != 2'd0)) begin
                    seq_err = 1'b1;
                end
                // Bottom must be low at top rise
                if (top_rise && bot) begin
                    seq_err = 1'b1;
                end
            end else if (bot_rise && q.bot_count == 2'd2) begin
                // Up to two bottom rises accepted
                seq_err = 1'b1;
            end
            // Start must rise in top zone or be high at overrun fall
            if (q.ctrl[pcm_pkg::CTRL_OVR_EN] && ovr_fall && !q.start_ok && !start_in) begin
                ovr_err = 1'b1;
            end
        end
    end

    assign wr_go = q.awv & q.wv & ~q.bvalid;

    always_comb begin
        d = q;
        d.top_sync = {q.top_sync[1:0], top_position_contact};
        d.bot_sync = {q.bot_sync[1:0], bottom_position_contact};
        d.ovr_sync = {q.ovr_sync[1:0], overrun_zone_contact};
        d.rst_sync = {q.rst_sync[1:0], restart_in};
        d.top_prev = top;
        d.bot_prev = bot;
        d.ovr_prev = ovr;
        d.rst_prev = rst;
        d.start_prev = start_in;
        d.rel_prev = release_in;

        // Millisecond timebase drives the high-time counter
        if (rst && !q.rst_prev) begin
            d.tick_cnt = 16'h0000;
            d.ms_cnt = 16'h0000;
            d.pulse_live = 1'b1;
        end else if (rst && q.pulse_live) begin
            if (q.tick_cnt == 16'(pcm_pkg::TICK_CYC - 1)) begin
                d.tick_cnt = 16'h0000;
                if (q.ms_cnt > 16'(pcm_pkg::MAX_PULSE_MS)) begin
                    d.pulse_live = 1'b0;
                end else begin
                    d.ms_cnt = q.ms_cnt + 16'h0001;
                end
            end else begin
                d.tick_cnt = q.tick_cnt + 16'h0001;
            end
        end else if (!rst) begin
            d.pulse_live = 1'b0;
        end

        // Per-cycle bookkeeping restarts when the top contact falls
        if (top_fall) begin
            d.bot_count = 2'd0;
            d.ovr_seen = 1'b0;
            d.up_used = 1'b0;
            d.bot_armed = 1'b1;
        end
        if (bot_rise && q.bot_count != 2'd3) begin
            d.bot_count = q.bot_count + 2'd1;
        end
        if (ovr_rise) begin
            d.ovr_seen = 1'b1;
        end
        if (top_rise) begin
            d.start_ok = 1'b0;
        end else if (start_rise && q.out.top_zone) begin
            d.start_ok = 1'b1;
        end

        // Bottom rise while top high opens upstroke zone
        if (bot_rise && top && !q.up_used && q.bot_armed) begin
            d.out.upstroke_zone = 1'b1;
            d.up_used = 1'b1;
        end
        // First top or bottom fall closes it
        if (top_fall || bot_fall) begin
            d.out.upstroke_zone = 1'b0;
        end
        if (top_rise) begin
            d.out.top_zone = 1'b1;
        end
        if (top_fall) begin
            d.out.top_zone = 1'b0;
        end

        // Latch fault, drop release, demand rearm
        if (seq_err) begin
            d.out.sequence_fault = 1'b1;
        end
        if (ovr_err) begin
            d.out.overrun_fault = 1'b1;
        end
        // Clear only by a valid pulse when restart is enabled
        if (q.out.rearm_needed && pulse_ok && q.ctrl[pcm_pkg::CTRL_RESTART_EN]
                && !seq_err && !ovr_err) begin
            d.out.sequence_fault = 1'b0;
            d.out.overrun_fault = 1'b0;
            d.bot_armed = ~bot;
        end
        d.out.rearm_needed = d.out.sequence_fault | d.out.overrun_fault;
        if (d.out.rearm_needed || !release_in) begin
            d.out.top_zone = 1'b0;
            d.out.upstroke_zone = 1'b0;
        end
        if (!release_in && top) begin
            d.out.top_zone = 1'b0;
        end else if (release_in && !q.rel_prev && !d.out.rearm_needed) begin
            d.out.top_zone = top;
        end
        d.out.release_out = release_in & ~d.out.rearm_needed;
        d.out.any_fault = q.ctrl[pcm_pkg::CTRL_FLAG_EN] & d.out.rearm_needed;

        // Register slave: one write and one read at a time
        if (s_axi_awvalid && !q.awv) begin
            d.awv = 1'b1;
            d.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !q.wv) begin
            d.wv = 1'b1;
            d.wdata = s_axi_wdata;
        end
        if (wr_go) begin
            d.awv = 1'b0;
            d.wv = 1'b0;
            d.bvalid = 1'b1;
            d.bresp = pcm_pkg::RESP_OKAY;
            // Control word holds the overrun enable and other settings
            if (q.awaddr[7:2] == pcm_pkg::ADDR_CTRL[7:2] && q.awaddr[31:8] == 24'h00_0000) begin
                if (s_axi_wstrb[0]) begin
                    d.ctrl = q.wdata[4:0];
                end
            end else if (q.awaddr[7:2] != pcm_pkg::ADDR_STAT[7:2]
                    || q.awaddr[31:8] != 24'h00_0000) begin
                d.bresp = pcm_pkg::RESP_SLVERR;
            end
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end
        if (s_axi_arvalid && !q.rvalid) begin
            d.rvalid = 1'b1;
            d.rresp = pcm_pkg::RESP_OKAY;
            if (s_axi_araddr == pcm_pkg::ADDR_CTRL) begin
                d.rdata = {27'h000_0000, q.ctrl};
            end else if (s_axi_araddr == pcm_pkg::ADDR_STAT) begin
                d.rdata = {25'h000_0000, q.out};
            end else begin
                d.rdata = 32'h0000_0000;
                d.rresp = pcm_pkg::RESP_SLVERR;
            end
        end else if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= '0;
            q.ctrl <= pcm_pkg::CTRL_RESET;
            // Overrun contact rests high: start its filter there, so no false rise
            q.ovr_sync <= 3'h7;
            q.ovr_prev <= 1'b1;
            // Bottom rest level is low, so the first cycle may open upstroke
            q.bot_armed <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign release_out = q.out.release_out;
    assign top_zone = q.out.top_zone;
    assign upstroke_zone = q.out.upstroke_zone;
    assign rearm_needed = q.out.rearm_needed;
    assign sequence_fault = q.out.sequence_fault;
    assign overrun_fault = q.out.overrun_fault;
    assign any_fault = q.out.any_fault;
    assign s_axi_awready = ~q.awv;
    assign s_axi_wready = ~q.wv;
    assign s_axi_bvalid = q.bvalid;
    assign s_axi_bresp = q.bresp;
    assign s_axi_arready = ~q.rvalid;
    assign s_axi_rvalid = q.rvalid;
    assign s_axi_rdata = q.rdata;
    assign s_axi_rresp = q.rresp;

    a_fault_drops_release: assert property (@(posedge aclk) disable iff (!aresetn)
        rearm_needed |-> !release_out) else $error("release high with fault");
    a_seq_fault_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        seq_err |=> sequence_fault && rearm_needed) else $error("sequence fault missed");
    a_ovr_fault_sets: assert property (@(posedge aclk) disable iff (!aresetn)
        ovr_err |=> overrun_fault) else $error("overrun fault missed");
    a_flag_gated: assert property (@(posedge aclk) disable iff (!aresetn)
        any_fault |-> (sequence_fault || overrun_fault)) else $error("bad any_fault");
    a_flag_enabled: assert property (@(posedge aclk) disable iff (!aresetn)
        !q.ctrl[pcm_pkg::CTRL_FLAG_EN] && $stable(q.ctrl) |=> !any_fault)
        else $error("any_fault while disabled");
    a_no_clear_disabled: assert property (@(posedge aclk) disable iff (!aresetn)
        sequence_fault && !q.ctrl[pcm_pkg::CTRL_RESTART_EN] |=> sequence_fault)
        else $error("fault cleared with restart off");
    a_clear_needs_pulse: assert property (@(posedge aclk) disable iff (!aresetn)
        rearm_needed && !pulse_ok |=> rearm_needed) else $error("clear without pulse");
    a_pulse_window: assert property (@(posedge aclk) disable iff (!aresetn)
        pulse_ok |-> q.ms_cnt >= 16'd100 && q.ms_cnt <= 16'd30000)
        else $error("pulse outside window");
    a_release_low: assert property (@(posedge aclk) disable iff (!aresetn)
        !release_in |=> !release_out && !top_zone && !upstroke_zone)
        else $error("outputs high with release low");
    a_upstroke_drop: assert property (@(posedge aclk) disable iff (!aresetn)
        (top_fall || bot_fall) |=> !upstroke_zone) else $error("upstroke stayed high");

    c_upstroke: cover property (@(posedge aclk) disable iff (!aresetn) $rose(upstroke_zone));
    c_seq_fault: cover property (@(posedge aclk) disable iff (!aresetn) $rose(sequence_fault));
    c_ovr_fault: cover property (@(posedge aclk) disable iff (!aresetn) $rose(overrun_fault));
    c_rearm_done: cover property (@(posedge aclk) disable iff (!aresetn) $fell(rearm_needed));
endmodule : pcm_monitor

// ==== pcm_press_model.sv ====
/* Far-side model: the three press contacts and the downstream drive command.
   Assumes callers step it from just after a rising edge of aclk. */
`timescale 1ns/1ps
module pcm_press_model (
    input wire logic aclk,
    output logic top_position_contact,
    output logic bottom_position_contact,
    output logic overrun_zone_contact,
    output logic start_in
);
    // Resting at the top: top contact low, overrun zone high
    initial begin
        top_position_contact = 1'b0;
        bottom_position_contact = 1'b0;
        overrun_zone_contact = 1'b1;
        start_in = 1'b1;
    end
    // Hold is long enough to pass the three-flop pin filter
    task automatic move(input logic t, input logic b, input logic o, input int hold);
        top_position_contact <= t;
        bottom_position_contact <= b;
        overrun_zone_contact <= o;
        repeat (hold) @(posedge aclk);
    endtask : move
    task automatic drive(input logic on);
        start_in <= on;
        @(posedge aclk);
    endtask : drive
    // one overrun pulse, bottom low at top rise
    task automatic press_cycle(input int nb, input int hold);
        move(1'b1, 1'b0, 1'b1, hold);
        move(1'b1, 1'b0, 1'b0, hold);
        for (int i = 0; i < nb; i++) begin
            move(1'b1, 1'b1, 1'b0, hold);
            move(1'b1, 1'b0, 1'b0, hold);
        end
        move(1'b1, 1'b0, 1'b1, hold);
        move(1'b0, 1'b0, 1'b1, hold);
    endtask : press_cycle
endmodule : pcm_press_model

// ==== press_contact_monitor_test.sv ====
/* Self-checking bench for the press contact monitor.
   Assumes the press model on the contact side; AXI4-Lite is driven here. */
`timescale 1ns/1ps
module press_contact_monitor_test;
    logic aclk, aresetn, restart_in, release_in;
    logic top_position_contact, bottom_position_contact, overrun_zone_contact, start_in;
    logic release_out, top_zone, upstroke_zone, rearm_needed;
    logic zone_seen;
    logic sequence_fault, overrun_fault, any_fault;
    logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rs;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
    logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int fail_count = 0;
    int checks = 0;
    // Order: release, upstroke, rearm, sequence, overrun, any
    wire logic [5:0] flags = {release_out, upstroke_zone, rearm_needed,
        sequence_fault, overrun_fault, any_fault};

    pcm_press_model far (.aclk, .top_position_contact, .bottom_position_contact,
        .overrun_zone_contact, .start_in);
    pcm_monitor uut (.aclk, .aresetn, .top_position_contact, .bottom_position_contact,
        .overrun_zone_contact, .restart_in, .start_in, .release_in, .release_out,
        .top_zone, .upstroke_zone, .rearm_needed, .sequence_fault, .overrun_fault,
        .any_fault, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
        .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic complete_run;
        $display("checks %0d fail_count %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : complete_run

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            $display("FAIL %s expected %h seen %h", what, exp, got);
            fail_count++;
        end
    endtask : cmp

    task automatic hung(input string what);
        $display("FAIL %s expected answer seen timeout", what);
        fail_count++;
        complete_run();
    endtask : hung

    task automatic axi_write(input logic [31:0] a, input logic [31:0] d);
        logic aw_ok, w_ok, b_ok;
        int n;
        aw_ok = 1'b0;
        w_ok = 1'b0;
        b_ok = 1'b0;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_ok) begin
            @(posedge aclk);
            b_ok = aw_ok && w_ok && s_axi_bvalid;
            if (!aw_ok && s_axi_awready) begin
                aw_ok = 1'b1;
                s_axi_awvalid <= 1'b0;
            end
            if (!w_ok && s_axi_wready) begin
                w_ok = 1'b1;
                s_axi_wvalid <= 1'b0;
            end
            n++;
            if (n > 64) hung("write");
        end
        s_axi_bready <= 1'b0;
        cmp("bresp", 32'h0000_0000, s_axi_bresp);
        // Let one edge pass so a following call does not re-drive bready now
        @(posedge aclk);
    endtask : axi_write

    task automatic axi_read(input logic [31:0] a);
        logic ar_ok, r_ok;
        int n;
        ar_ok = 1'b0;
        r_ok = 1'b0;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_ok) begin
            @(posedge aclk);
            r_ok = ar_ok && s_axi_rvalid;
            rd = s_axi_rdata;
            rs = s_axi_rresp;
            if (!ar_ok && s_axi_arready) begin
                ar_ok = 1'b1;
                s_axi_arvalid <= 1'b0;
            end
            n++;
            if (n > 64) hung("read");
        end
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : axi_read

    task automatic pulse_restart;
        restart_in <= 1'b1;
        repeat (40) @(posedge aclk);
        restart_in <= 1'b0;
        repeat (8) @(posedge aclk);
    endtask : pulse_restart

    task automatic t_regs;
        axi_read(pcm_pkg::ADDR_CTRL);
        cmp("ctrl reset", 32'h0000_0001, rd);
        axi_read(32'h0000_0010);
        cmp("unmapped resp", {30'h0, pcm_pkg::RESP_SLVERR}, rs);
        cmp("unmapped data", 32'h0000_0000, rd);
        axi_write(pcm_pkg::ADDR_CTRL, 32'h0000_0013);
        axi_read(pcm_pkg::ADDR_CTRL);
        cmp("ctrl back", 32'h0000_0013, rd);
    endtask : t_regs

    task automatic t_cycle;
        cmp("idle", 6'b10_0000, flags);
        far.move(1'b1, 1'b0, 1'b1, 8);
        zone_seen = top_zone;
        cmp("top zone on", 32'h0000_0001, zone_seen);
        far.move(1'b1, 1'b0, 1'b0, 8);
        far.move(1'b1, 1'b1, 1'b0, 8);
        cmp("upstroke on", 6'b11_0000, flags);
        far.move(1'b1, 1'b0, 1'b0, 8);
        cmp("upstroke off", 6'b10_0000, flags);
        far.move(1'b1, 1'b0, 1'b1, 8);
        far.move(1'b0, 1'b0, 1'b1, 20);
        cmp("clean cycle", 6'b10_0000, flags);
        zone_seen = top_zone;
        cmp("top zone off", 32'h0000_0000, zone_seen);
    endtask : t_cycle

    task automatic t_suspend;
        release_in <= 1'b0;
        far.press_cycle(0, 8);
        cmp("suspended", 6'b00_0000, flags);
        release_in <= 1'b1;
        repeat (8) @(posedge aclk);
        cmp("resumed", 6'b10_0000, flags);
    endtask : t_suspend

    task automatic t_fault;
        far.press_cycle(0, 8);
        cmp("no bottom", 6'b00_1101, flags);
        pulse_restart();
        cmp("short pulse", 6'b00_1101, flags);
        axi_write(pcm_pkg::ADDR_CTRL, 32'h0000_0003);
        repeat (4) @(posedge aclk);
        cmp("flag off", 6'b00_1100, flags);
    endtask : t_fault

    task automatic t_restart_off;
        axi_write(pcm_pkg::ADDR_CTRL, 32'h0000_0002);
        pulse_restart();
        cmp("held", 6'b00_1100, flags);
        aresetn <= 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        cmp("after reset", 6'b10_0000, flags);
    endtask : t_restart_off

    task automatic t_range;
        axi_write(pcm_pkg::ADDR_CTRL, 32'h0000_0016);
        far.move(1'b1, 1'b0, 1'b1, 8);
        far.move(1'b1, 1'b0, 1'b0, 8);
        far.move(1'b1, 1'b1, 1'b0, 8);
        far.move(1'b1, 1'b0, 1'b0, 8);
        far.move(1'b1, 1'b1, 1'b0, 8);
        cmp("second rise", 6'b10_0000, flags);
        far.move(1'b1, 1'b0, 1'b0, 8);
        far.move(1'b1, 1'b0, 1'b1, 8);
        far.move(1'b0, 1'b0, 1'b1, 8);
        far.press_cycle(0, 8);
        cmp("two then none", 6'b10_0000, flags);
        far.drive(1'b0);
        far.press_cycle(1, 8);
        cmp("start missing", 6'b00_1011, flags);
    endtask : t_range

    initial begin
        aresetn = 1'b0;
        restart_in = 1'b0;
        release_in = 1'b1;
        s_axi_awaddr = 32'h0000_0000;
        s_axi_wdata = 32'h0000_0000;
        s_axi_araddr = 32'h0000_0000;
        s_axi_wstrb = 4'hf;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid = 1'b0;
        s_axi_bready = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready = 1'b0;
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (8) @(posedge aclk);
        t_regs();
        t_cycle();
        t_suspend();
        t_fault();
        t_restart_off();
        t_range();
        complete_run();
    end
endmodule : press_contact_monitor_test
